// ==== logic/dram_host_regs.vh ====
`ifndef DRAM_HOST_REGS_VH
`define DRAM_HOST_REGS_VH

// Command codes on cmdOp
`define OP_CBR_REFRESH    4'h0
`define OP_ROW_REFRESH    4'h1
`define OP_READ           4'h2
`define OP_WRITE          4'h3
`define OP_MASKED_WRITE   4'h4
`define OP_BLOCK_FILL     4'h5
`define OP_MASKED_BLOCK   4'h6
`define OP_ROW_FILL       4'h7
`define OP_FILL_LOAD      4'h8
`define OP_FILL_READ      4'h9
`define OP_READ_XFER      4'hA
`define OP_SPLIT_READ     4'hB
`define OP_MASKED_XFER    4'hC
`define OP_MASKED_SPLIT   4'hD

// Strobe-time level vector {colStrobeN, transferOutputEnableN, writeStrobesN, functionSelect}
`define LV_CAS            3
`define LV_TRG            2
`define LV_WE             1
`define LV_FS             0

// Timing
`define CLK_PERIOD_NS     20
`define PHASE_NS          40
`define SHIFT_HALF_CYC    4

// Block fill keeps the three low column bits internal
`define BLOCK_COL_LSBS    3
`define BYTE_W            8

`endif

// ==== logic/word_fifo.v ====
`timescale 1ns/1ps
module word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             nrst,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_ff;
    reg [AW-1:0]    rdPtr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;
    integer         i;

    assign inReady  = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != {(AW+1){1'b0}});
    assign outData  = mem_ff[rdPtr_ff];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_ff[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_ff[wrPtr_ff] <= inData;
                wrPtr_ff         <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                       : wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                               : rdPtr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // word_fifo

// ==== logic/dram_host.v ====
`timescale 1ns/1ps
`include "dram_host_regs.vh"
module dram_host #(
    parameter DW         = 16,
    parameter AW         = 9,
    parameter FIFO_DEPTH = 4,
    parameter SHIFT_HALF = `SHIFT_HALF_CYC
) (
    // Clock and reset
    input  wire          core_clk,
    input  wire          nrst,
    // Command port
    input  wire          cmdValid,
    output reg           cmdReady_ff,
    input  wire [3:0]    cmdOp,
    input  wire [AW-1:0] cmdRow,
    input  wire [AW-1:0] cmdCol,
    input  wire [DW-1:0] cmdData,
    input  wire [DW-1:0] cmdMask,
    input  wire [1:0]    cmdByteEn,
    // Answer port
    output reg           rspValid_ff,
    output reg  [DW-1:0] rspData_ff,
    // Serial stream
    input  wire          swValid,
    output wire          swReady,
    input  wire [DW-1:0] swData,
    input  wire          srEnable,
    output reg           srValid_ff,
    output reg  [DW-1:0] srData_ff,
    output reg           shiftDirOut_ff,
    output reg           halfStatus_ff,
    // RAM port pins
    output reg           rowStrobeN_ff,
    output reg           colStrobeN_ff,
    output reg           transferOutputEnableN_ff,
    output reg           lowerWriteStrobeN_ff,
    output reg           upperWriteStrobeN_ff,
    output reg           functionSelect_ff,
    output reg  [AW-1:0] addr_ff,
    input  wire [DW-1:0] ramIoIn,
    output reg  [DW-1:0] ramIoOut_ff,
    output reg           ramIoOe_ff,
    // Shift port pins
    output reg           shiftClock_ff,
    output reg           shiftPortGateN_ff,
    input  wire [DW-1:0] shiftIoIn,
    output reg  [DW-1:0] shiftIoOut_ff,
    output reg           shiftIoOe_ff,
    input  wire          halfIndicator
);
    localparam PHASE = (`PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam [2:0] S_IDLE = 3'h0, S_RSET = 3'h1, S_RLOW = 3'h2, S_CSET = 3'h3,
                     S_CLOW = 3'h4, S_DATA = 3'h5, S_PRE = 3'h6;

    // Levels presented at the row strobe fall
    function [3:0] rasLevels;
        input [3:0] op;
        begin
            case (op)
                `OP_CBR_REFRESH:  rasLevels = 4'h7;
                `OP_ROW_REFRESH,
                `OP_READ,
                `OP_WRITE,
                `OP_BLOCK_FILL:   rasLevels = 4'hE;
                `OP_MASKED_WRITE,
                `OP_MASKED_BLOCK: rasLevels = 4'hC;
                `OP_ROW_FILL:     rasLevels = 4'hD;
                `OP_FILL_LOAD,
                `OP_FILL_READ:    rasLevels = 4'hF;
                `OP_READ_XFER:    rasLevels = 4'hA;
                `OP_SPLIT_READ:   rasLevels = 4'hB;
                `OP_MASKED_XFER:  rasLevels = 4'h8;
                `OP_MASKED_SPLIT: rasLevels = 4'h9;
                default:          rasLevels = 4'hE;
            endcase
        end
    endfunction

    function fsAtCas;
        input [3:0] op;
        begin
            fsAtCas = (op == `OP_BLOCK_FILL) || (op == `OP_MASKED_BLOCK) ||
                      (op == `OP_FILL_LOAD) || (op == `OP_FILL_READ);
        end
    endfunction

    reg  [2:0]    state_ff;
    reg  [2:0]    tmr_ff;
    reg  [3:0]    op_ff;
    reg  [AW-1:0] col_ff;
    reg  [DW-1:0] data_ff;
    reg  [DW-1:0] mask_ff;
    reg  [1:0]    be_ff;
    reg  [DW-1:0] ramSync1_ff, ramSync2_ff;
    reg  [DW-1:0] shSync1_ff, shSync2_ff;
    reg           halfSync1_ff, halfSync2_ff;
    reg  [2:0]    scDiv_ff;
    reg           primed_ff;
    wire [3:0]    lv      = rasLevels(op_ff);
    wire          tmrDone = (tmr_ff == 3'h0);
    wire          isXfer  = !lv[`LV_TRG];
    wire          isRead  = (op_ff == `OP_READ) || (op_ff == `OP_FILL_READ);
    wire          noCas   = (op_ff == `OP_CBR_REFRESH) || (op_ff == `OP_ROW_REFRESH) ||
                            (op_ff == `OP_ROW_FILL);
    wire          isBlock = (op_ff == `OP_BLOCK_FILL) || (op_ff == `OP_MASKED_BLOCK);
    wire          fifoValid;
    wire [DW-1:0] fifoData;
    wire          active  = shiftDirOut_ff ? srEnable : fifoValid;
    wire          divWrap = (scDiv_ff == SHIFT_HALF[2:0] - 3'h1);
    wire          riseNow = divWrap && !shiftClock_ff && active;
    wire          popNow  = riseNow && !shiftDirOut_ff;

    word_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
        .core_clk (core_clk),
        .nrst     (nrst),
        .inValid  (swValid),
        .inReady  (swReady),
        .inData   (swData),
        .outValid (fifoValid),
        .outReady (popNow),
        .outData  (fifoData)
    );

    // Pin inputs pass two flops first
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ramSync1_ff  <= {DW{1'b0}};
            ramSync2_ff  <= {DW{1'b0}};
            shSync1_ff   <= {DW{1'b0}};
            shSync2_ff   <= {DW{1'b0}};
            halfSync1_ff <= 1'b0;
            halfSync2_ff <= 1'b0;
        end else begin
            ramSync1_ff  <= ramIoIn;
            ramSync2_ff  <= ramSync1_ff;
            shSync1_ff   <= shiftIoIn;
            shSync2_ff   <= shSync1_ff;
            halfSync1_ff <= halfIndicator;
            halfSync2_ff <= halfSync1_ff;
        end
    end

    // RAM port sequencer
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff                 <= S_IDLE;
            tmr_ff                   <= 3'h0;
            op_ff                    <= `OP_READ;
            col_ff                   <= {AW{1'b0}};
            data_ff                  <= {DW{1'b0}};
            mask_ff                  <= {DW{1'b0}};
            be_ff                    <= 2'h0;
            cmdReady_ff              <= 1'b0;
            rspValid_ff              <= 1'b0;
            rspData_ff               <= {DW{1'b0}};
            shiftDirOut_ff           <= 1'b1;
            rowStrobeN_ff            <= 1'b1;
            colStrobeN_ff            <= 1'b1;
            transferOutputEnableN_ff <= 1'b1;
            lowerWriteStrobeN_ff     <= 1'b1;
            upperWriteStrobeN_ff     <= 1'b1;
            functionSelect_ff        <= 1'b0;
            addr_ff                  <= {AW{1'b0}};
            ramIoOut_ff              <= {DW{1'b0}};
            ramIoOe_ff               <= 1'b0;
        end else begin
            rspValid_ff <= 1'b0;
            if (!tmrDone) begin
                tmr_ff <= tmr_ff - 3'h1;
            end
            case (state_ff)
                S_IDLE: begin
                    cmdReady_ff <= 1'b1;
                    if (cmdValid && cmdReady_ff) begin
                        cmdReady_ff <= 1'b0;
                        op_ff       <= cmdOp;
                        col_ff      <= cmdCol;
                        data_ff     <= cmdData;
                        mask_ff     <= cmdMask;
                        be_ff       <= cmdByteEn;
                        addr_ff     <= cmdRow;
                        tmr_ff      <= PHASE[2:0];
                        state_ff    <= S_RSET;
                    end
                end
                S_RSET: begin
                    colStrobeN_ff            <= lv[`LV_CAS];
                    transferOutputEnableN_ff <= lv[`LV_TRG];
                    lowerWriteStrobeN_ff     <= lv[`LV_WE];
                    upperWriteStrobeN_ff     <= lv[`LV_WE];
                    functionSelect_ff        <= lv[`LV_FS];
                    ramIoOut_ff              <= mask_ff;
                    ramIoOe_ff               <= !lv[`LV_WE];
                    if (tmrDone) begin
                        rowStrobeN_ff <= 1'b0;
                        tmr_ff        <= PHASE[2:0];
                        state_ff      <= S_RLOW;
                    end
                end
                S_RLOW: begin
                    if (tmrDone) begin
                        ramIoOe_ff           <= 1'b0;
                        lowerWriteStrobeN_ff <= 1'b1;
                        upperWriteStrobeN_ff <= 1'b1;
                        if (isXfer && !lv[`LV_FS]) begin
                            shiftDirOut_ff <= lv[`LV_WE];
                        end
                        tmr_ff   <= PHASE[2:0];
                        state_ff <= noCas ? S_PRE : S_CSET;
                    end
                end
                S_CSET: begin
                    addr_ff           <= isBlock ? {col_ff[AW-1:`BLOCK_COL_LSBS],
                                         {`BLOCK_COL_LSBS{1'b0}}} : col_ff;
                    functionSelect_ff <= fsAtCas(op_ff);
                    if (!isXfer && !isRead) begin
                        // Write data, column mask or fill value on the pins
                        transferOutputEnableN_ff <= 1'b1;
                        ramIoOut_ff              <= data_ff;
                        ramIoOe_ff               <= 1'b1;
                        // Strobes fall before the column strobe: early write
                        lowerWriteStrobeN_ff <= !be_ff[0];
                        upperWriteStrobeN_ff <= !be_ff[1];
                    end
                    if (tmrDone) begin
                        colStrobeN_ff <= 1'b0;
                        tmr_ff        <= PHASE[2:0];
                        state_ff      <= S_CLOW;
                    end
                end
                S_CLOW: begin
                    if (isRead) begin
                        transferOutputEnableN_ff <= 1'b0;
                    end
                    if (tmrDone) begin
                        transferOutputEnableN_ff <= !isRead;
                        // Extra margin covers the input synchroniser
                        tmr_ff   <= PHASE[2:0] + 3'h2;
                        state_ff <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (tmrDone) begin
                        if (isRead) begin
                            rspValid_ff <= 1'b1;
                            rspData_ff  <= ramSync2_ff;
                        end
                        tmr_ff   <= PHASE[2:0];
                        state_ff <= S_PRE;
                    end
                end
                S_PRE: begin
                    rowStrobeN_ff            <= 1'b1;
                    colStrobeN_ff            <= 1'b1;
                    transferOutputEnableN_ff <= 1'b1;
                    lowerWriteStrobeN_ff     <= 1'b1;
                    upperWriteStrobeN_ff     <= 1'b1;
                    functionSelect_ff        <= 1'b0;
                    ramIoOe_ff               <= 1'b0;
                    if (tmrDone) begin
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    // Shift port: clock made here by dividing core_clk
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scDiv_ff          <= 3'h0;
            shiftClock_ff     <= 1'b0;
            shiftPortGateN_ff <= 1'b1;
            shiftIoOut_ff     <= {DW{1'b0}};
            shiftIoOe_ff      <= 1'b0;
            primed_ff         <= 1'b0;
            srValid_ff        <= 1'b0;
            srData_ff         <= {DW{1'b0}};
            halfStatus_ff     <= 1'b0;
        end else begin
            srValid_ff <= 1'b0;
            // Gate only enables access; the pointer still steps on every rising edge
            shiftPortGateN_ff <= !active;
            shiftIoOe_ff      <= !shiftDirOut_ff && fifoValid;
            if (!shiftPortGateN_ff) begin
                halfStatus_ff <= halfSync2_ff;
            end
            if (!active) begin
                primed_ff <= 1'b0;
            end
            if (active || shiftClock_ff) begin
                scDiv_ff <= divWrap ? 3'h0 : scDiv_ff + 3'h1;
                if (divWrap) begin
                    shiftClock_ff <= !shiftClock_ff;
                end
            end
            // Present the head word half a period before the rise
            if (divWrap && shiftClock_ff) begin
                shiftIoOut_ff <= fifoData;
            end else if (!shiftIoOe_ff) begin
                shiftIoOut_ff <= fifoData;
            end
            // Word from the previous rise sampled just before the next one
            if (riseNow && shiftDirOut_ff) begin
                primed_ff <= 1'b1;
                if (primed_ff) begin
                    srValid_ff <= 1'b1;
                    srData_ff  <= shSync2_ff;
                end
            end
        end
    end
endmodule // dram_host

// ==== sim/dram_host_monitor.sv ====
`timescale 1ns/1ps
module dram_host_monitor #(
    parameter DW = 16
) (
    // Clock and reset
    input wire          core_clk,
    input wire          nrst,
    // RAM port
    input wire          rowStrobeN_ff,
    input wire          colStrobeN_ff,
    input wire          transferOutputEnableN_ff,
    input wire          lowerWriteStrobeN_ff,
    input wire          upperWriteStrobeN_ff,
    input wire          functionSelect_ff,
    input wire          ramIoOe_ff,
    // Shift port
    input wire          shiftClock_ff,
    input wire          shiftPortGateN_ff,
    input wire [DW-1:0] shiftIoOut_ff,
    input wire          shiftIoOe_ff,
    input wire          shiftDirOut_ff
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire       weHi = lowerWriteStrobeN_ff & upperWriteStrobeN_ff;
    reg  [2:0] lv_ff;
    // Levels frozen at the row fall, for the whole row cycle
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            lv_ff <= 3'h0;
        else if (rowStrobeN_ff)
            lv_ff <= {transferOutputEnableN_ff, functionSelect_ff, weHi};
    end
    property p_mask_on_pins;
        $fell(rowStrobeN_ff) && colStrobeN_ff && !weHi |-> ramIoOe_ff;
    endproperty
    a_mask_on_pins: assert property (p_mask_on_pins) else $error("mask absent");
    property p_cbr_quiet;
        $fell(rowStrobeN_ff) && !colStrobeN_ff |-> !ramIoOe_ff [*4];
    endproperty
    a_cbr_quiet: assert property (p_cbr_quiet) else $error("refresh drove pins");
    property p_fill_read;
        $fell(colStrobeN_ff) && lv_ff == 3'h7 && weHi |-> weHi throughout (##[0:40] rowStrobeN_ff);
    endproperty
    a_fill_read: assert property (p_fill_read) else $error("fill read broken");
    property p_write_trg;
        !rowStrobeN_ff && !colStrobeN_ff && lv_ff[2] && ramIoOe_ff |-> transferOutputEnableN_ff;
    endproperty
    a_write_trg: assert property (p_write_trg) else $error("drive with enable low");
    property p_read_release;
        !rowStrobeN_ff && !colStrobeN_ff && lv_ff[2] && !transferOutputEnableN_ff && weHi
            |-> !ramIoOe_ff;
    endproperty
    a_read_release: assert property (p_read_release) else $error("read contention");
    property p_sdata_setup;
        $rose(shiftClock_ff) && shiftIoOe_ff |-> $stable(shiftIoOut_ff) && $past(shiftIoOe_ff);
    endproperty
    a_sdata_setup: assert property (p_sdata_setup) else $error("serial data moved");
    property p_sio_mode;
        shiftIoOe_ff |-> !shiftPortGateN_ff && !shiftDirOut_ff;
    endproperty
    a_sio_mode: assert property (p_sio_mode) else $error("serial drive bad mode");
endmodule // dram_host_monitor

// ==== sim/dram_device_model.sv ====
`timescale 1ns/1ps
module dram_device_model (
    // RAM port
    input wire         rowStrobeN,
    input wire         colStrobeN,
    input wire         transferOutputEnableN,
    input wire         lowerWriteStrobeN,
    input wire         upperWriteStrobeN,
    input wire         functionSelect,
    input wire [8:0]   addr,
    input wire [15:0]  ramIoOut,
    input wire         ramIoOe,
    output wire [15:0] ramIo,
    // Shift port
    input wire         shiftClock,
    input wire         shiftPortGateN,
    input wire [15:0]  shiftIoOut,
    input wire         shiftIoOe,
    output wire [15:0] shiftIo,
    output wire        halfIndicator
);
    reg  [15:0] mem [0:262143];
    reg  [15:0] shift_register_array [0:511];
    reg  [15:0] fillVal, wMask;
    reg  [8:0]  row, col, ptr;
    reg  [3:0]  lv;
    reg         fsCol, dirOut = 1'b1;
    integer     k;
    wire        weHi = lowerWriteStrobeN & upperWriteStrobeN;
    wire [15:0] byteM = {{8{~upperWriteStrobeN}}, {8{~lowerWriteStrobeN}}};
    wire        acc = lv[3] & lv[2];
    wire        fill_value_load = acc & lv[1] & lv[0];
    wire        devOe = !rowStrobeN & !colStrobeN & !transferOutputEnableN & weHi & acc
                        & (fill_value_load | !fsCol);
    wire [15:0] devOut = fill_value_load ? fillVal : mem[{row, col}];
    // Released lines show the inverse, never a stale copy
    assign ramIo = ramIoOe ? ramIoOut : devOe ? devOut : ~devOut;
    assign shiftIo = shiftIoOe ? shiftIoOut : ~shiftPortGateN & dirOut ? shift_register_array[ptr] : ~shift_register_array[ptr];
    assign halfIndicator = shiftPortGateN ? ~ptr[8] : ptr[8];
    task automatic wr(input [17:0] a, input [15:0] d, input [15:0] m);
        mem[a] = (mem[a] & ~m) | (d & m);
    endtask
    always @(negedge rowStrobeN) begin
        row = addr;
        lv = {colStrobeN, transferOutputEnableN, weHi, functionSelect};
        wMask = weHi ? 16'hFFFF : ramIo;
        if (lv == 4'hD)
            for (k = 0; k < 512; k++) wr({row, k[8:0]}, fillVal, wMask);
    end
    always @(negedge colStrobeN) if (!rowStrobeN && lv[3]) begin
        col = addr;
        fsCol = functionSelect;
        if (!lv[2]) begin
            ptr = col;
            for (k = 0; k < 512; k++) if (!lv[0] || k[8] == col[8]) begin
                if (lv[1]) shift_register_array[k] = mem[{row, k[8:0]}];
                else wr({row, k[8:0]}, shift_register_array[k], wMask);
            end
            if (!lv[0]) dirOut = lv[1];
        end else if (fill_value_load) begin
            if (!weHi) fillVal = ramIo;
        end else if (!lv[0]) begin
            if (fsCol)
                for (k = 0; k < 8; k++)
                    wr({row, col[8:3], k[2:0]}, fillVal, wMask & {{8{ramIo[8+k]}}, {8{ramIo[k]}}});
            else if (!weHi) wr({row, col}, ramIo, wMask & byteM);
        end
    end
    always @(negedge lowerWriteStrobeN or negedge upperWriteStrobeN)
        if (!rowStrobeN && !colStrobeN && acc) begin
            if (fill_value_load) fillVal = ramIo;
            else if (!lv[0] && !fsCol) wr({row, col}, ramIo, wMask & byteM);
        end
    always @(posedge shiftClock) begin
        if (!shiftPortGateN && !dirOut) shift_register_array[ptr] = shiftIo;
        ptr = ptr + 9'h001;
    end
endmodule // dram_device_model

// ==== sim/dram_host_tb_top.sv ====
`timescale 1ns/1ps
`include "dram_host_regs.vh"
module dram_host_tb_top;
    reg         core_clk = 0, nrst = 0, cmdValid = 0, swValid = 0, srEnable = 0;
    reg  [3:0]  cmdOp = 0;
    reg  [8:0]  cmdRow = 0, cmdCol = 0;
    reg  [15:0] cmdData = 0, cmdMask = 0, swData = 0;
    reg  [1:0]  cmdByteEn = 0;
    wire        cmdReady_ff, rspValid_ff, swReady, srValid_ff, shiftDirOut_ff, halfStatus_ff;
    wire        rowStrobeN_ff, colStrobeN_ff, transferOutputEnableN_ff, lowerWriteStrobeN_ff;
    wire        upperWriteStrobeN_ff, functionSelect_ff, ramIoOe_ff, shiftClock_ff;
    wire        shiftPortGateN_ff, shiftIoOe_ff, halfIndicator;
    wire [8:0]  addr_ff;
    wire [15:0] rspData_ff, srData_ff, ramIoIn, ramIoOut_ff, shiftIoIn, shiftIoOut_ff;
    integer     err_total = 0, check_count = 0, cyc = 0;
    dram_host dut_u (.*);
    dram_device_model dev_u (.rowStrobeN(rowStrobeN_ff), .colStrobeN(colStrobeN_ff),
        .transferOutputEnableN(transferOutputEnableN_ff), .lowerWriteStrobeN(lowerWriteStrobeN_ff),
        .upperWriteStrobeN(upperWriteStrobeN_ff), .functionSelect(functionSelect_ff),
        .addr(addr_ff), .ramIoOut(ramIoOut_ff), .ramIoOe(ramIoOe_ff), .ramIo(ramIoIn),
        .shiftClock(shiftClock_ff), .shiftPortGateN(shiftPortGateN_ff), .shiftIoOut(shiftIoOut_ff),
        .shiftIoOe(shiftIoOe_ff), .shiftIo(shiftIoIn), .halfIndicator(halfIndicator));
    initial forever #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            give_verdict;
        end
    end
    task give_verdict;
        if (err_total == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task check(input [63:0] name, input [15:0] seen, input [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task cmd(input [3:0] op, input [8:0] r, c, input [15:0] d, m, input [1:0] be);
        integer n;
        @(negedge core_clk);
        {cmdOp, cmdRow, cmdCol, cmdData, cmdMask, cmdByteEn} = {op, r, c, d, m, be};
        cmdValid = 1;
        for (n = 0; n < 200 && cmdReady_ff !== 1'b1; n++) @(negedge core_clk);
        @(negedge core_clk) cmdValid = 0;
    endtask
    task rd(input [3:0] op, input [8:0] r, c, output [15:0] q);
        integer n;
        cmd(op, r, c, 16'h0000, 16'h0000, 2'h0);
        for (n = 0; n < 100 && rspValid_ff !== 1'b1; n++) @(negedge core_clk);
        q = rspData_ff;
    endtask
    // Wait until the running cycle has ended
    task settle;
        integer n;
        for (n = 0; n < 100 && cmdReady_ff !== 1'b1; n++) @(negedge core_clk);
    endtask
    task sc_access;
        reg [15:0] q;
        cmd(`OP_WRITE, 9'h005, 9'h00A, 16'h1234, 16'h0000, 2'h3);
        cmd(`OP_WRITE, 9'h005, 9'h00A, 16'hABCD, 16'h0000, 2'h2);
        rd(`OP_READ, 9'h005, 9'h00A, q); check("byte", q, 16'hAB34);
        cmd(`OP_MASKED_WRITE, 9'h005, 9'h00A, 16'hFFFF, 16'h00F0, 2'h3);
        rd(`OP_READ, 9'h005, 9'h00A, q); check("mask", q, 16'hABF4);
    endtask
    task sc_fill;
        reg [15:0] q;
        integer k;
        cmd(`OP_FILL_LOAD, 9'h002, 9'h000, 16'h5A5A, 16'h0000, 2'h3);
        cmd(`OP_CBR_REFRESH, 9'h000, 9'h000, 16'h0000, 16'h0000, 2'h0);
        cmd(`OP_ROW_REFRESH, 9'h005, 9'h000, 16'h0000, 16'h0000, 2'h0);
        rd(`OP_FILL_READ, 9'h002, 9'h000, q); check("fillrd", q, 16'h5A5A);
        rd(`OP_READ, 9'h005, 9'h00A, q); check("refresh", q, 16'hABF4);
        for (k = 0; k < 8; k++) cmd(`OP_WRITE, 9'h007, 9'h018 + k, 16'h0000, 16'h0000, 2'h3);
        cmd(`OP_BLOCK_FILL, 9'h007, 9'h01D, 16'h0F81, 16'h0000, 2'h3);
        for (k = 0; k < 8; k++) begin
            rd(`OP_READ, 9'h007, 9'h018 + k, q);
            check("block", q, {k < 4 ? 8'h5A : 8'h00, k % 7 == 0 ? 8'h5A : 8'h00});
        end
        cmd(`OP_MASKED_BLOCK, 9'h007, 9'h018, 16'hFFFF, 16'hFF00, 2'h3);
        rd(`OP_READ, 9'h007, 9'h01C, q); check("mblock", q, 16'h5A00);
        cmd(`OP_WRITE, 9'h009, 9'h003, 16'h0000, 16'h0000, 2'h3);
        cmd(`OP_ROW_FILL, 9'h009, 9'h000, 16'h0000, 16'h00FF, 2'h3);
        rd(`OP_READ, 9'h009, 9'h003, q); check("rowfill", q, 16'h005A);
    endtask
    task sc_xfer;
        reg [15:0] q, w1;
        integer k, n, refused;
        for (k = 0; k < 6; k++) cmd(`OP_WRITE, 9'h003, 9'h104 + k, 16'h1104 + k, 16'h0000, 2'h3);
        cmd(`OP_READ_XFER, 9'h003, 9'h104, 16'h0000, 16'h0000, 2'h0);
        settle;
        check("dirout", shiftDirOut_ff, 16'h0001);
        srEnable = 1;
        for (n = 0; n < 100 && srValid_ff !== 1'b1; n++) @(negedge core_clk);
        w1 = srData_ff;
        @(negedge core_clk);
        for (n = 0; n < 100 && srValid_ff !== 1'b1; n++) @(negedge core_clk);
        q = srData_ff;
        srEnable = 0;
        check("step", q - w1, 16'h0001);
        check("tap", {8'h00, w1[15:8]}, 16'h0011);
        check("half", halfStatus_ff, 16'h0001);
        cmd(`OP_MASKED_XFER, 9'h004, 9'h000, 16'h0000, 16'hFFFF, 2'h0);
        settle;
        check("dirin", shiftDirOut_ff, 16'h0000);
        cmd(`OP_SPLIT_READ, 9'h003, 9'h100, 16'h0000, 16'h0000, 2'h0);
        settle;
        check("split", shiftDirOut_ff, 16'h0000);
        refused = 0;
        for (k = 0; k < 6; k++) begin
            swValid = 1;
            swData = 16'hC000 + k;
            for (n = 0; n < 100 && swReady !== 1'b1; n++) @(negedge core_clk);
            refused = refused + n;
            @(negedge core_clk);
        end
        swValid = 0;
        check("full", refused > 0, 16'h0001);
        // Drained once the shift port has been quiet for a while
        n = 0;
        for (k = 0; k < 400 && n < 16; k++) begin
            @(negedge core_clk);
            n = (shiftIoOe_ff || shiftClock_ff) ? 0 : n + 1;
        end
        cmd(`OP_MASKED_SPLIT, 9'h006, 9'h000, 16'h0000, 16'hFFFF, 2'h0);
        cmd(`OP_MASKED_XFER, 9'h006, 9'h000, 16'h0000, 16'hFFFF, 2'h0);
        for (k = 0; k < 6; k++) begin
            rd(`OP_READ, 9'h006, 9'h100 + k, q);
            check("swrite", q, 16'hC000 + k);
        end
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) nrst = 1;
        sc_access;
        sc_fill;
        sc_xfer;
        give_verdict;
    end
endmodule // dram_host_tb_top
bind dram_host dram_host_monitor #(.DW(DW)) mon_u (.*);
